//--- meas_block_src.sv
`timescale 1ns/100ps
`default_nettype none
`include "prog_stage_params.svh"
module meas_block_src (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rstn, // async reset, active low
  input wire logic signed [`VAL_W-1:0] meas_req, // wanted measurement
  input wire logic blk_req, // wanted blocking state
  output logic signed [`VAL_W-1:0] meas_in, // measurement to stage
  output logic block_in // blocking line to stage
);
  // flopped so the stage never sees a change away from a clock edge
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meas_in <= 40'sh0000000000;
      block_in <= 1'b0;
    end
    else
    begin
      meas_in <= meas_req;
      // level held for whole ticks, raised long before expiry
      block_in <= blk_req;
    end
  end
endmodule : meas_block_src
`default_nettype wire

//--- prog_stage_n.sv
`timescale 1ns/100ps
`default_nettype none
`include "prog_stage_params.svh"
module prog_stage_n #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLE_CYC
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rstn, // async reset, active low
  input wire logic signed [`VAL_W-1:0] meas_in, // selected measurement
  input wire logic signed [`VAL_W-1:0] mag_mult, // magnitude multiplier
  input wire logic [2:0] cmp_mode, // comparator mode
  input wire logic signed [`VAL_W-1:0] pickup_level_one, // pick-up level
  input wire logic [`HYST_W-1:0] hyst_set, // hysteresis, 0.0001 % lsb
  input wire logic signed [`VAL_W-1:0] block_limit, // under-mode limit
  input wire logic [`DELAY_W-1:0] op_delay, // operate delay, steps
  input wire logic [`DELAY_W-1:0] rel_delay, // release delay, steps
  input wire logic block_in, // blocking matrix line
  input wire logic [5:0] evt_mask, // event enables, see hand-over
  input wire logic [`STAMP_W-1:0] time_stamp, // current time stamp
  input wire logic [`SG_W-1:0] setting_group, // active setting group
  input wire logic [`LOG_IDX_W-1:0] log_sel, // log entry to read
  output logic start_o, // start output
  output logic trip_o, // trip output
  output logic blocked_o, // blocked output
  output logic [1:0] condition, // condition code
  output logic [`REMAIN_W-1:0] remain_ms, // time left to trip, ms
  output logic signed [`VAL_W-1:0] scaled_mag, // scaled magnitude
  output logic signed [`VAL_W-1:0] mag_ratio, // magnitude / pick-up
  output logic [5:0] evt_pulse, // start/trip/block on,off
  output logic [`LOG_IDX_W-1:0] log_count, // valid log entries
  output logic [`STAMP_W-1:0] log_stamp, // selected entry stamp
  output logic [1:0] log_event, // selected entry event code
  output logic signed [`VAL_W-1:0] log_mag, // selected entry magnitude
  output logic signed [`VAL_W-1:0] log_ratio, // selected entry ratio
  output logic [`REMAIN_W-1:0] log_remain, // selected entry time left
  output logic [`SG_W-1:0] log_sg // selected entry setting group
);

  ////////////////////////////////////////////////////////////////////////
  // program cycle
  logic [31:0] tick_cnt_r;
  logic tick;
  logic blk_r;
  logic blk_nxt;

  assign tick = (tick_cnt_r == 32'(PROG_CYCLES - 1));
  // start is gated in the same edge that takes the new block level
  assign blk_nxt = tick ? block_in : blk_r;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      tick_cnt_r <= 32'h0;
    else if (tick)
      tick_cnt_r <= 32'h0;
    else
      tick_cnt_r <= tick_cnt_r + 32'h1;

  // block level only changes at a program cycle boundary
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      blk_r <= 1'b0;
    else if (tick)
      blk_r <= block_in;

  ////////////////////////////////////////////////////////////////////////
  // scaling, history and ratio
  logic signed [2*`VAL_W-1:0] prod;
  logic signed [`VAL_W-1:0] scaled_nxt;
  logic signed [`VAL_W-1:0] hist_r [`DELTA_WIN_CYC];
  logic signed [2*`VAL_W-1:0] ratio_wide;

  assign prod = meas_in * mag_mult;
  assign scaled_nxt = `VAL_W'(prod / 80'(`FRAC_SCALE));
  // ratio keeps four decimals, like the settings
  assign ratio_wide = (scaled_mag * 80'(`FRAC_SCALE))
    / 80'(pickup_level_one);

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      scaled_mag <= '0;
      mag_ratio <= '0;
    end
    else if (tick)
    begin
      scaled_mag <= scaled_nxt;
      if (pickup_level_one == '0)
        mag_ratio <= '0;
      else
        mag_ratio <= `VAL_W'(ratio_wide);
    end

  // oldest entry lags the current sample by the 20 ms window
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      for (int i = 0; i < `DELTA_WIN_CYC; i++)
        hist_r[i] <= '0;
    end
    else if (tick)
    begin
      hist_r[0] <= scaled_mag;
      for (int i = 1; i < `DELTA_WIN_CYC; i++)
        hist_r[i] <= hist_r[i-1];
    end

  ////////////////////////////////////////////////////////////////////////
  // comparator
  logic pick_r, pick_nxt;
  logic signed [95:0] x, pu, band, pu_abs, old_abs, d;
  logic signed [95:0] thr_over, thr_under, thr_mag, x_abs, d_abs;

  always_comb
  begin
    x = 96'(scaled_mag);
    pu = 96'(pickup_level_one);
    d = x - 96'(hist_r[`DELTA_WIN_CYC-1]);
    x_abs = (x < 0) ? -x : x;
    d_abs = (d < 0) ? -d : d;
    pu_abs = (pu < 0) ? -pu : pu;
    old_abs = (hist_r[`DELTA_WIN_CYC-1] < 0)
      ? -96'(hist_r[`DELTA_WIN_CYC-1]) : 96'(hist_r[`DELTA_WIN_CYC-1]);
    band = (pu_abs * 96'(hyst_set)) / `HYST_SCALE;
    // once picked up, the threshold moves back by the band
    thr_over = pick_r ? pu - band : pu;
    thr_under = pick_r ? pu + band : pu;
    thr_mag = pick_r ? pu_abs - band : pu_abs;
    pick_nxt = 1'b0;
    case (prog_stage_pkg::cmp_mode_type'(cmp_mode))
      prog_stage_pkg::CMP_OVER:
        pick_nxt = x > thr_over;
      prog_stage_pkg::CMP_OVER_ABS:
        pick_nxt = x_abs > thr_over;
      prog_stage_pkg::CMP_UNDER:
        pick_nxt = (x < thr_under) && !(x < 96'(block_limit));
      prog_stage_pkg::CMP_UNDER_ABS:
        pick_nxt = (x_abs < thr_under)
          && !(x_abs < 96'(block_limit));
      prog_stage_pkg::CMP_DELTA_REL:
        // d / |old| in 0.0001 % units, kept free of division
        if (pu < 0)
          pick_nxt = d * `HYST_SCALE < thr_under * old_abs;
        else
          pick_nxt = d * `HYST_SCALE > thr_over * old_abs;
      prog_stage_pkg::CMP_DELTA_RELAB:
        pick_nxt = d_abs * `HYST_SCALE > thr_mag * old_abs;
      prog_stage_pkg::CMP_DELTA_VAL:
        pick_nxt = (pu < 0) ? d < thr_under : d > thr_over;
      prog_stage_pkg::CMP_DELTA_VALAB:
        pick_nxt = d_abs > thr_mag;
      default:
        pick_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      pick_r <= 1'b0;
    else if (tick)
      pick_r <= pick_nxt;

  ////////////////////////////////////////////////////////////////////////
  // stage sequencing
  prog_stage_pkg::stage_state_type st_r, st_nxt;
  logic [`DELAY_W-1:0] op_cnt_r, op_cnt_nxt, rel_cnt_r, rel_cnt_nxt;
  logic trip_hold_r, trip_hold_nxt;

  always_comb
  begin
    st_nxt = st_r;
    op_cnt_nxt = op_cnt_r;
    rel_cnt_nxt = rel_cnt_r;
    trip_hold_nxt = trip_hold_r;
    if (tick)
      case (st_r)
        prog_stage_pkg::ST_NORMAL:
          if (pick_r)
          begin
            op_cnt_nxt = '0;
            st_nxt = blk_r ? prog_stage_pkg::ST_BLOCKED
              : prog_stage_pkg::ST_START;
          end
        prog_stage_pkg::ST_START:
          if (blk_r || !pick_r)
          begin
            rel_cnt_nxt = '0;
            st_nxt = prog_stage_pkg::ST_RELEASE;
          end
          else if (op_cnt_r + 19'h1 >= op_delay)
          begin
            trip_hold_nxt = 1'b1;
            st_nxt = prog_stage_pkg::ST_TRIP;
          end
          else
            op_cnt_nxt = op_cnt_r + 19'h1;
        prog_stage_pkg::ST_TRIP:
          if (blk_r || !pick_r)
          begin
            rel_cnt_nxt = '0;
            st_nxt = prog_stage_pkg::ST_RELEASE;
          end
        prog_stage_pkg::ST_RELEASE:
          if (pick_r && !blk_r)
            st_nxt = trip_hold_r ? prog_stage_pkg::ST_TRIP
              : prog_stage_pkg::ST_START;
          else if (rel_cnt_r + 19'h1 >= rel_delay)
          begin
            trip_hold_nxt = 1'b0;
            st_nxt = prog_stage_pkg::ST_NORMAL;
          end
          else
            rel_cnt_nxt = rel_cnt_r + 19'h1;
        prog_stage_pkg::ST_BLOCKED:
          if (!pick_r || !blk_r)
            st_nxt = prog_stage_pkg::ST_NORMAL;
        default:
          st_nxt = prog_stage_pkg::ST_NORMAL;
      endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      st_r <= prog_stage_pkg::ST_NORMAL;
      op_cnt_r <= '0;
      rel_cnt_r <= '0;
      trip_hold_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      op_cnt_r <= op_cnt_nxt;
      rel_cnt_r <= rel_cnt_nxt;
      trip_hold_r <= trip_hold_nxt;
    end

  // outputs follow the state; trip stays up through the release delay
  logic start_r, trip_r, blocked_r;
  logic [`REMAIN_W-1:0] remain_r;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      start_r <= 1'b0;
      trip_r <= 1'b0;
      blocked_r <= 1'b0;
      remain_r <= '0;
    end
    else
    begin
      start_r <= (st_nxt == prog_stage_pkg::ST_START
        || st_nxt == prog_stage_pkg::ST_TRIP) && !blk_nxt;
      trip_r <= trip_hold_nxt;
      blocked_r <= st_nxt == prog_stage_pkg::ST_BLOCKED;
      if (st_nxt == prog_stage_pkg::ST_START)
        remain_r <= `REMAIN_W'((op_delay - op_cnt_nxt) * `STEP_MS);
      else
        remain_r <= '0;
    end

  assign start_o = start_r;
  assign trip_o = trip_r;
  assign blocked_o = blocked_r;
  assign remain_ms = remain_r;
  assign condition = blocked_r ? `COND_BLOCKED
    : trip_r ? `COND_TRIP : start_r ? `COND_START : `COND_NORMAL;

  ////////////////////////////////////////////////////////////////////////
  // events and log
  logic start_d_r, trip_d_r, blocked_d_r;
  logic [5:0] raw_evt;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      start_d_r <= 1'b0;
      trip_d_r <= 1'b0;
      blocked_d_r <= 1'b0;
    end
    else
    begin
      start_d_r <= start_r;
      trip_d_r <= trip_r;
      blocked_d_r <= blocked_r;
    end

  assign raw_evt = {blocked_d_r & ~blocked_r, blocked_r & ~blocked_d_r,
    trip_d_r & ~trip_r, trip_r & ~trip_d_r,
    start_d_r & ~start_r, start_r & ~start_d_r};
  assign evt_pulse = raw_evt & evt_mask;

  logic [`STAMP_W-1:0] lg_stamp [`LOG_DEPTH];
  logic [1:0] lg_event [`LOG_DEPTH];
  logic signed [`VAL_W-1:0] lg_mag [`LOG_DEPTH];
  logic signed [`VAL_W-1:0] lg_ratio [`LOG_DEPTH];
  logic [`REMAIN_W-1:0] lg_remain [`LOG_DEPTH];
  logic [`SG_W-1:0] lg_sg [`LOG_DEPTH];
  logic [`LOG_IDX_W-1:0] wr_ptr_r, count_r;
  logic log_we;

  // one on-event per cycle is logged; blocked wins, then trip
  assign log_we = raw_evt[4] | raw_evt[2] | raw_evt[0];

  always_ff @(posedge ref_clk)
    if (log_we)
    begin
      lg_stamp[wr_ptr_r] <= time_stamp;
      lg_event[wr_ptr_r] <= raw_evt[4] ? `COND_BLOCKED
        : raw_evt[2] ? `COND_TRIP : `COND_START;
      lg_mag[wr_ptr_r] <= scaled_mag;
      lg_ratio[wr_ptr_r] <= mag_ratio;
      lg_remain[wr_ptr_r] <= remain_r;
      lg_sg[wr_ptr_r] <= setting_group;
    end

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      wr_ptr_r <= '0;
      count_r <= '0;
    end
    else if (log_we)
    begin
      wr_ptr_r <= (wr_ptr_r == 4'(`LOG_DEPTH - 1)) ? '0 : wr_ptr_r + 4'h1;
      if (count_r != 4'(`LOG_DEPTH))
        count_r <= count_r + 4'h1;
    end

  assign log_count = count_r;

  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      log_stamp <= '0;
      log_event <= '0;
      log_mag <= '0;
      log_ratio <= '0;
      log_remain <= '0;
      log_sg <= '0;
    end
    else if (log_sel < count_r)
    begin
      log_stamp <= lg_stamp[log_sel];
      log_event <= lg_event[log_sel];
      log_mag <= lg_mag[log_sel];
      log_ratio <= lg_ratio[log_sel];
      log_remain <= lg_remain[log_sel];
      log_sg <= lg_sg[log_sel];
    end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_cond_blocked;
    @(posedge ref_clk) disable iff (!rstn)
    blocked_o |-> condition == 2'h3 && !start_o;
  endproperty
  a_cond_blocked: assert property (p_cond_blocked)
    else $error("blocked without condition code 3");

  property p_start_gated;
    @(posedge ref_clk) disable iff (!rstn)
    start_o |-> !blk_r;
  endproperty
  a_start_gated: assert property (p_start_gated)
    else $error("start while blocking active");

  property p_block_hold;
    @(posedge ref_clk) disable iff (!rstn)
    !tick |=> blk_r == $past(blk_r);
  endproperty
  a_block_hold: assert property (p_block_hold)
    else $error("block sampled off the program cycle");

  property p_pick_start;
    @(posedge ref_clk) disable iff (!rstn)
    tick && st_r == prog_stage_pkg::ST_NORMAL && pick_r && !blk_r
      && !block_in |=> start_o;
  endproperty
  a_pick_start: assert property (p_pick_start)
    else $error("pick-up did not start");

  property p_block_drop;
    @(posedge ref_clk) disable iff (!rstn)
    tick && st_r == prog_stage_pkg::ST_START && blk_r
      |=> !start_o && st_r == prog_stage_pkg::ST_RELEASE;
  endproperty
  a_block_drop: assert property (p_block_drop)
    else $error("block did not drop start into release");

  property p_trip_after_start;
    @(posedge ref_clk) disable iff (!rstn)
    $rose(trip_o) |-> $past(start_o) || $past(st_r) ==
      prog_stage_pkg::ST_RELEASE;
  endproperty
  a_trip_after_start: assert property (p_trip_after_start)
    else $error("trip without prior start");

  property p_remain_load;
    @(posedge ref_clk) disable iff (!rstn)
    $rose(start_o) && !trip_o && $past(st_r) == prog_stage_pkg::ST_NORMAL
      |-> remain_ms == `REMAIN_W'(op_delay * `STEP_MS);
  endproperty
  a_remain_load: assert property (p_remain_load)
    else $error("remaining time not loaded with operate delay");

  property p_evt_pulse;
    @(posedge ref_clk) disable iff (!rstn)
    raw_evt[3] |-> ##1 !raw_evt[3] ##0 !trip_o;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse)
    else $error("trip off event not a single pulse");

  property p_log_count;
    @(posedge ref_clk) disable iff (!rstn)
    log_we && count_r < 4'(`LOG_DEPTH) |=> count_r == $past(count_r) + 4'h1;
  endproperty
  a_log_count: assert property (p_log_count)
    else $error("log count did not advance");

endmodule : prog_stage_n
`default_nettype wire

//--- prog_stage_params.svh
`ifndef PROG_STAGE_PARAMS_SVH
`define PROG_STAGE_PARAMS_SVH

// magnitude values in fixed point, one lsb = 0.0001
`define VAL_W 40
`define FRAC_SCALE 40'sh0000002710
// hysteresis lsb = 0.0001 %, so full scale of a fraction is 1e6
`define HYST_SCALE 96'sh0000000000000000000f4240
`define HYST_W 20
`define HYST_DEFAULT 20'h07530
`define PICKUP_DEFAULT 40'sh0000000064

// timing: one program cycle is one delay step
`define CLK_PERIOD_NS 10
`define PROG_CYCLE_US 5000
`define PROG_CYCLE_CYC ((`PROG_CYCLE_US * 1000) / `CLK_PERIOD_NS)
`define DELTA_WIN_MS 20
`define DELTA_WIN_CYC ((`DELTA_WIN_MS * 1000) / `PROG_CYCLE_US)
`define STEP_MS 5
`define DELAY_W 19
`define DELAY_MAX 19'h57e40
`define OP_DELAY_DEFAULT 19'h00008
`define REL_DELAY_DEFAULT 19'h0000c
`define REMAIN_W 21

// condition codes
`define COND_NORMAL 2'h0
`define COND_START 2'h1
`define COND_TRIP 2'h2
`define COND_BLOCKED 2'h3

// event log
`define LOG_DEPTH 12
`define LOG_IDX_W 4
`define STAMP_W 64
`define SG_W 3

`endif

//--- prog_stage_pkg.sv
`default_nettype none
package prog_stage_pkg;

  typedef enum logic [4:0] {
    ST_NORMAL  = 5'b00001,
    ST_START   = 5'b00010,
    ST_TRIP    = 5'b00100,
    ST_RELEASE = 5'b01000,
    ST_BLOCKED = 5'b10000
  } stage_state_type;

  typedef enum logic [2:0] {
    CMP_OVER        = 3'h0,
    CMP_OVER_ABS    = 3'h1,
    CMP_UNDER       = 3'h2,
    CMP_UNDER_ABS   = 3'h3,
    CMP_DELTA_REL   = 3'h4,
    CMP_DELTA_RELAB = 3'h5,
    CMP_DELTA_VAL   = 3'h6,
    CMP_DELTA_VALAB = 3'h7
  } cmp_mode_type;

endpackage : prog_stage_pkg
`default_nettype wire

//--- programmable_comparator_stage_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "prog_stage_params.svh"
module programmable_comparator_stage_tb_top;
  localparam int PC = 8;
  localparam int MD [11] = '{0, 1, 2, 3, 2, 4, 4, 5, 6, 6, 7};
  localparam int M0 [11] = '{0, 0, 200, 200, 200, 10000, 10000, 10000,
                             10000, 10000, 10000};
  localparam int M1 [11] = '{200, -200, 50, -50, -50, 20000, 5000, 5000,
                             20000, 5000, 5000};
  localparam bit EX [11] = '{1, 1, 1, 1, 0, 1, 0, 1, 1, 0, 1};
  logic ref_clk, rstn, blk_req, block_in;
  logic signed [`VAL_W-1:0] meas_req, meas_in, pickup_level_one;
  logic [2:0] cmp_mode;
  logic [`HYST_W-1:0] hyst_set;
  logic [`DELAY_W-1:0] op_delay, rel_delay;
  logic [`LOG_IDX_W-1:0] log_sel, log_count;
  logic start_o, trip_o, blocked_o;
  logic [1:0] condition;
  logic [`REMAIN_W-1:0] remain_ms;
  logic signed [`VAL_W-1:0] scaled_mag, mag_ratio, log_mag;
  logic [5:0] evt_pulse, evt_seen;
  logic [`SG_W-1:0] log_sg;
  int errors, num_checks, n;

  meas_block_src i_src (.ref_clk(ref_clk), .rstn(rstn), .meas_req(meas_req),
    .blk_req(blk_req), .meas_in(meas_in), .block_in(block_in));

  prog_stage_n #(.PROG_CYCLES(PC)) i_dut (.ref_clk(ref_clk), .rstn(rstn),
    .meas_in(meas_in), .mag_mult(40'sh0000002710), .cmp_mode(cmp_mode),
    .pickup_level_one(pickup_level_one), .hyst_set(hyst_set),
    .block_limit(40'sh0000000000), .op_delay(op_delay),
    .rel_delay(rel_delay), .block_in(block_in), .evt_mask(6'h3f),
    .time_stamp(64'h0000000000000000), .setting_group(3'h5),
    .log_sel(log_sel), .start_o(start_o), .trip_o(trip_o),
    .blocked_o(blocked_o), .condition(condition), .remain_ms(remain_ms),
    .scaled_mag(scaled_mag), .mag_ratio(mag_ratio), .evt_pulse(evt_pulse),
    .log_count(log_count), .log_stamp(), .log_event(), .log_mag(log_mag),
    .log_ratio(), .log_remain(), .log_sg(log_sg));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // pulses last one cycle, so they are collected for later comparison
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      evt_seen <= 6'h00;
    else
      evt_seen <= evt_seen | evt_pulse;
  end

  ////////////////////////////////////////////////////////////////////////////
  task check(input string nm, input logic [63:0] seen, input logic [63:0] ex);
    begin
      num_checks++;
      if (seen !== ex)
      begin
        errors++;
        $display("[ERR] %s expected %0h seen %0h", nm, ex, seen);
      end
    end
  endtask : check

  task test_done;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask : test_done

  // w selects start, trip or blocked; n is the cycle count, -1 on timeout
  task wait_for(input int w, input logic v, input int lim, input bit must);
    logic s;
    begin
      n = -1;
      for (int k = 1; k <= lim && n < 0; k++)
      begin
        @(posedge ref_clk);
        #1;
        s = (w == 0) ? start_o : (w == 1) ? trip_o : blocked_o;
        if (s === v)
          n = k;
      end
      if (n < 0 && must)
      begin
        errors++;
        $display("[ERR] wait %0d expected %0b seen timeout", w, v);
        test_done;
      end
    end
  endtask : wait_for

  task do_reset;
    begin
      @(posedge ref_clk);
      rstn <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
    end
  endtask : do_reset

  task set_meas(input int v);
    begin
      @(posedge ref_clk);
      meas_req <= `VAL_W'(v);
    end
  endtask : set_meas

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    blk_req = 1'b0;
    meas_req = 40'sh0000000000;
    pickup_level_one = 40'sh0000000064;
    cmp_mode = 3'h0;
    hyst_set = 20'h07530;
    op_delay = 19'h00003;
    rel_delay = 19'h00003;
    log_sel = 4'h0;
    errors = 0;
    num_checks = 0;
    #1;
    check("reset cond", {start_o, trip_o, blocked_o, condition}, 0);
    do_reset;
    // pick-up, timed operate, trip, then release
    set_meas(200);
    wait_for(0, 1'b1, 6 * PC, 1'b1);
    check("cond start", condition, `COND_START);
    check("remain", remain_ms, 15);
    check("scaled", scaled_mag, 200);
    check("ratio", mag_ratio, 20000);
    repeat (PC) @(posedge ref_clk);
    #1;
    check("remain step", remain_ms, 10);
    wait_for(1, 1'b1, 4 * PC, 1'b1);
    check("op delay", n, 2 * PC);
    check("cond trip", {start_o, condition}, {1'b1, `COND_TRIP});
    set_meas(0);
    wait_for(0, 1'b0, 6 * PC, 1'b1);
    wait_for(1, 1'b0, 6 * PC, 1'b1);
    check("rel delay", n, 3 * PC);
    @(posedge ref_clk);
    #1;
    check("events", evt_seen, 6'h0f);
    check("log count", log_count, 2);
    repeat (2) @(posedge ref_clk);
    #1;
    check("log mag", log_mag, 200);
    check("log sg", log_sg, 3'h5);
    // every comparator mode, rising and falling steps
    @(posedge ref_clk);
    op_delay <= 19'h00100;
    for (int i = 0; i < 11; i++)
    begin
      @(posedge ref_clk);
      cmp_mode <= MD[i][2:0];
      meas_req <= `VAL_W'(M0[i]);
      do_reset;
      // delta modes see a step from zero after reset; let it release
      repeat (12 * PC) @(posedge ref_clk);
      set_meas(M1[i]);
      wait_for(0, 1'b1, 8 * PC, 1'b0);
      check("mode start", n >= 0, EX[i]);
    end
    // hysteresis band of 3 % below a pick-up of 1.0
    @(posedge ref_clk);
    cmp_mode <= 3'h0;
    pickup_level_one <= 40'sh0000002710;
    meas_req <= 40'sh0000000000;
    do_reset;
    set_meas(10100);
    wait_for(0, 1'b1, 6 * PC, 1'b1);
    set_meas(9800);
    repeat (6 * PC) @(posedge ref_clk);
    #1;
    check("hyst hold", start_o, 1'b1);
    set_meas(9600);
    wait_for(0, 1'b0, 6 * PC, 1'b1);
    // blocked before pick-up: no start
    @(posedge ref_clk);
    pickup_level_one <= 40'sh0000000064;
    meas_req <= 40'sh0000000000;
    do_reset;
    blk_req <= 1'b1;
    set_meas(200);
    wait_for(2, 1'b1, 6 * PC, 1'b1);
    check("blk cond", {start_o, condition}, {1'b0, `COND_BLOCKED});
    repeat (4 * PC) @(posedge ref_clk);
    #1;
    check("blk gate", start_o, 1'b0);
    @(posedge ref_clk);
    // block arriving after start
    blk_req <= 1'b0;
    meas_req <= 40'sh0000000000;
    do_reset;
    set_meas(200);
    wait_for(0, 1'b1, 6 * PC, 1'b1);
    @(posedge ref_clk);
    blk_req <= 1'b1;
    wait_for(0, 1'b0, 2 * PC, 1'b1);
    check("blk drop", trip_o, 1'b0);
    wait_for(2, 1'b1, 6 * PC, 1'b1);
    @(posedge ref_clk);
    #1;
    check("blk event", evt_seen[4], 1'b1);
    // thirteen start events fill the circular log
    @(posedge ref_clk);
    blk_req <= 1'b0;
    rel_delay <= 19'h00001;
    meas_req <= 40'sh0000000000;
    do_reset;
    for (int i = 0; i < 13; i++)
    begin
      set_meas(200);
      wait_for(0, 1'b1, 6 * PC, 1'b1);
      set_meas(0);
      wait_for(0, 1'b0, 6 * PC, 1'b1);
      repeat (4 * PC) @(posedge ref_clk);
    end
    #1;
    check("log full", log_count, `LOG_DEPTH);
    test_done;
  end
endmodule : programmable_comparator_stage_tb_top
`default_nettype wire
